// ---- logic/vrs_pkg.sv ----
// ----------------------------------------------------------------
// shared constants of the start-up sequencer
// ----------------------------------------------------------------
package vrs_pkg;

  // clock period
  localparam int unsigned CLK_PERIOD_NS = 10;

  // internal reset cycle, least time, rounded up
  localparam int unsigned RESET_TIME_NS = 50000;
  localparam int unsigned RESET_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // power-good masking interval after a transition
  localparam int unsigned MASK_TIME_NS = 100000;
  localparam int unsigned MASK_CYCLES = (MASK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // keep-out after a code change, least time, rounded up
  localparam int unsigned VID_SETTLE_NS = 400;
  localparam logic [5:0] VID_SETTLE_CYCLES = 6'((VID_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // phase detection spans three oscillator cycles
  localparam logic [15:0] PHASE_DET_CYCLES = 16'h0003;

  // code decode in units of 100 uV: top level minus code times step
  localparam logic [15:0] VID_TOP_UV100 = 16'h3A98;   // 1.5 V
  localparam logic [15:0] VID_STEP_UV100 = 16'h007D;  // 12.5 mV
  localparam logic [15:0] WIN_LOW_FLOOR_UV100 = 16'h0BB8; // 300 mV
  localparam logic [6:0] BOOT_CODE = 7'h18;           // the 1.2 V code

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] CODE_OFS = 8'h08;
  localparam logic [7:0] EVENT_OFS = 8'h0C;
  // field positions and reset values
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RST = 1'b1;
  localparam int unsigned EVT_LATCH_BIT = 0;
  localparam int unsigned EVT_PGFAIL_BIT = 1;
  localparam int unsigned EVT_ILIM_BIT = 2;

  // sequencer states
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_RESET = 3'b001,
    ST_PHASE = 3'b010,
    ST_SOFT = 3'b011,
    ST_RUN = 3'b100,
    ST_LATCHED = 3'b101
  } vrs_state_t;

endpackage : vrs_pkg

// ---- logic/vrs_seq.sv ----
// Behaviour
// - lockout clear and enable start timed reset
// - phase detect after reset, then ramp go
// - soft-start node held zero when off
// - 8 uA source charges soft-start during ramp
// - ramp target is fixed 1.2 V boot code
// - clock enable at 1.7 V if in window
// - after clock enable, follow processor code
// - soft-start fast-charged to 2.9 V clamp
// - delay node held zero before clock enable
// - 2 uA source charges delay node afterwards
// - power ok at 2.9 V delay and in window
// - delay length set by external capacitor
// - disable or low supply discharges both nodes
// - open-drain power ok follows window
// - window is -300 mV to +200 mV
// - below 300 mV target, upper limit only
// - mask failures 100 us after transitions
// - extend mask on 200 mV sleep drop
// - current limit forces full-phase mode
// - decode 7-bit code to target
// - ignore new code for 400 ns
// - each code change restarts mask timer
// - fault discharges soft-start; latch below 1.65 V
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module vrs_seq #(
  parameter int unsigned RESET_CYCLES_P = vrs_pkg::RESET_CYCLES,
  parameter int unsigned MASK_CYCLES_P = vrs_pkg::MASK_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // supply, enable and system signals
  input wire logic chip_enable_input,
  input wire logic supply_above_upper,
  input wire logic supply_above_lower,
  input wire logic [6:0] voltage_id_code,
  input wire logic deeper_sleep_request,
  input wire logic low_power_state_indicator,
  // comparator flags from the analog side
  input wire logic phase2_pulled_high,
  input wire logic phase3_pulled_high,
  input wire logic ss_at_1v7,
  input wire logic ss_at_clamp,
  input wire logic ss_below_1v65,
  input wire logic delay_at_2v9,
  input wire logic vout_above_low_limit,
  input wire logic vout_below_high_limit,
  input wire logic vout_drop_200mv,
  input wire logic current_limit,
  // analog controls
  output logic bias_enable,
  output logic ss_discharge,
  output logic ss_charge_8ua,
  output logic ss_fast_charge,
  output logic ss_sink_2ua,
  output logic pok_delay_discharge,
  output logic pok_delay_charge_2ua,
  output logic [6:0] dac_code,
  output logic [15:0] dac_target_uv100,
  output logic [1:0] phase_count,
  output logic full_phase_mode,
  // processor facing
  output logic cpu_clock_enable_n,
  output logic power_ok_o,
  output logic power_ok_oe
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  vrs_pkg::vrs_state_t state_q, state_d;
  logic [15:0] cnt_q;          // reset and phase-detect timer
  logic [15:0] mask_cnt_q;     // power-good masking timer
  logic [5:0] deb_cnt_q;       // code keep-out timer
  logic [6:0] vid_last_q;      // raw code seen last cycle
  logic [6:0] vid_act_q;       // accepted code
  logic [1:0] phase_cnt_q;     // detected number of phases
  logic cpu_clock_enable_n_n_q;
  logic power_ok_q;
  logic fault_q;               // latch-off delay running
  logic ds_last_q;             // deeper sleep, previous cycle
  logic ds_mask_q;             // mask armed by a sleep transition
  logic sw_enable_q;
  logic [2:0] evt_q;
  logic [31:0] prdata_q;
  logic go;                    // enable and supply conditions met
  logic mask_active;
  logic target_low;
  logic in_window;
  logic pg_fail;
  logic vid_change;
  logic ds_change;
  logic [2:0] evt_set;
  logic acc;

  // ----------------------------------------------------------------
  // code decode and window
  // ----------------------------------------------------------------
  // boot code until the clock is enabled, processor code after
  assign dac_code = (state_q == vrs_pkg::ST_RUN) ? vid_act_q : vrs_pkg::BOOT_CODE;
  // linear decode; the window comparators are set around this target
  assign dac_target_uv100 = vrs_pkg::VID_TOP_UV100 - vrs_pkg::VID_STEP_UV100 * {9'h000, dac_code};
  assign target_low = dac_target_uv100 < vrs_pkg::WIN_LOW_FLOOR_UV100;
  // the lower limit is meaningless near zero volts, so drop it there
  assign in_window = vout_below_high_limit && (vout_above_low_limit || target_low);
  assign pg_fail = (state_q == vrs_pkg::ST_RUN) && !in_window && !mask_active;
  assign go = chip_enable_input && supply_above_lower && sw_enable_q;

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  // next state; loss of enable or supply always wins
  always_comb begin
    state_d = state_q;
    case (state_q)
      vrs_pkg::ST_OFF: begin
        if (go && supply_above_upper) begin
          state_d = vrs_pkg::ST_RESET;
        end
      end
      vrs_pkg::ST_RESET: begin
        if (cnt_q == 16'(RESET_CYCLES_P - 1)) begin
          state_d = vrs_pkg::ST_PHASE;
        end
      end
      vrs_pkg::ST_PHASE: begin
        if (cnt_q == vrs_pkg::PHASE_DET_CYCLES - 16'h0001) begin
          state_d = vrs_pkg::ST_SOFT;
        end
      end
      vrs_pkg::ST_SOFT: begin
        if (ss_at_1v7 && in_window) begin
          state_d = vrs_pkg::ST_RUN;
        end
      end
      vrs_pkg::ST_RUN: begin
        if (fault_q && ss_below_1v65) begin
          state_d = vrs_pkg::ST_LATCHED;
        end
      end
      vrs_pkg::ST_LATCHED: begin
        state_d = vrs_pkg::ST_LATCHED; // only loss of enable or supply clears it
      end
      default: begin
        state_d = vrs_pkg::ST_OFF;
      end
    endcase
    if (!go) begin
      state_d = vrs_pkg::ST_OFF;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= vrs_pkg::ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // shared timer, restarts on every state change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
    end else if (state_d != state_q) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q != 16'hFFFF) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // phase pins are sampled through the detection window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_cnt_q <= 2'h3;
    end else if (state_q == vrs_pkg::ST_PHASE) begin
      // a pulled-up pin disables its phase; pin 2 high implies single phase
      phase_cnt_q <= phase2_pulled_high ? 2'h1 : (phase3_pulled_high ? 2'h2 : 2'h3);
    end
  end
  assign phase_count = phase_cnt_q;

  // ----------------------------------------------------------------
  // code keep-out and masking
  // ----------------------------------------------------------------
  assign vid_change = (state_q == vrs_pkg::ST_RUN) && (voltage_id_code != vid_last_q);
  assign ds_change = (state_q == vrs_pkg::ST_RUN) && (deeper_sleep_request != ds_last_q);

  // raw code history and keep-out counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vid_last_q <= 7'h00;
      deb_cnt_q <= 6'h00;
      ds_last_q <= 1'b0;
    end else begin
      vid_last_q <= voltage_id_code;
      ds_last_q <= deeper_sleep_request;
      if (vid_change) begin
        deb_cnt_q <= vrs_pkg::VID_SETTLE_CYCLES - 6'h01;
      end else if (deb_cnt_q != 6'h00) begin
        deb_cnt_q <= deb_cnt_q - 6'h01;
      end
    end
  end

  // accepted code; skewed bits never reach the target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vid_act_q <= vrs_pkg::BOOT_CODE;
    end else if (state_q != vrs_pkg::ST_RUN) begin
      vid_act_q <= voltage_id_code; // first code read at clock enable
    end else if (!vid_change && deb_cnt_q == 6'h00) begin
      vid_act_q <= vid_last_q;
    end
  end

  // masking timer restarts on run entry and on every raw change while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_cnt_q <= 16'h0000;
    end else if (vid_change || ds_change || state_d == vrs_pkg::ST_RUN && state_q != vrs_pkg::ST_RUN) begin
      mask_cnt_q <= 16'(MASK_CYCLES_P);
    end else if (mask_cnt_q != 16'h0000) begin
      mask_cnt_q <= mask_cnt_q - 16'h0001;
    end
  end

  // a sleep transition keeps the mask while the droop lasts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ds_mask_q <= 1'b0;
    end else if (ds_change) begin
      ds_mask_q <= 1'b1;
    end else if (mask_cnt_q == 16'h0000 && !vout_drop_200mv) begin
      ds_mask_q <= 1'b0;
    end
  end
  assign mask_active = (mask_cnt_q != 16'h0000) || (ds_mask_q && vout_drop_200mv);

  // full phases during transitions, current limit or heavy load
  assign full_phase_mode = current_limit || mask_active
    || (low_power_state_indicator && !deeper_sleep_request);

  // ----------------------------------------------------------------
  // fault, clock enable and power ok
  // ----------------------------------------------------------------
  // fault runs while limit or window failure persists
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= (state_q == vrs_pkg::ST_RUN) && (current_limit || pg_fail);
    end
  end

  // clock enable held low only while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clock_enable_n_n_q <= 1'b1;
    end else begin
      cpu_clock_enable_n_n_q <= (state_d != vrs_pkg::ST_RUN);
    end
  end
  assign cpu_clock_enable_n = cpu_clock_enable_n_n_q;

  // power ok after the delay node terminates, masked on transitions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_ok_q <= 1'b0;
    end else begin
      power_ok_q <= (state_q == vrs_pkg::ST_RUN) && !cpu_clock_enable_n_n_q && delay_at_2v9
        && (in_window || mask_active);
    end
  end
  // open drain: pull low whenever not good
  assign power_ok_o = 1'b0;
  assign power_ok_oe = !power_ok_q;

  // ----------------------------------------------------------------
  // analog node controls
  // ----------------------------------------------------------------
  assign bias_enable = (state_q != vrs_pkg::ST_OFF);
  assign ss_discharge = (state_q == vrs_pkg::ST_OFF) || (state_q == vrs_pkg::ST_LATCHED) || !go;
  assign ss_charge_8ua = (state_q == vrs_pkg::ST_SOFT);
  assign ss_sink_2ua = (state_q == vrs_pkg::ST_RUN) && fault_q;
  // after a recovered fault the node climbs back to the clamp
  assign ss_fast_charge = (state_q == vrs_pkg::ST_RUN) && !fault_q && !ss_at_clamp;
  assign pok_delay_discharge = cpu_clock_enable_n_n_q || !go;
  assign pok_delay_charge_2ua = !cpu_clock_enable_n_n_q && go;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  assign acc = psel && penable;
  assign pready = 1'b1; // zero wait states
  assign pslverr = acc && (paddr != vrs_pkg::CTRL_OFS) && (paddr != vrs_pkg::STATUS_OFS)
    && (paddr != vrs_pkg::CODE_OFS) && (paddr != vrs_pkg::EVENT_OFS);

  // control register: software enable gates the start-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_enable_q <= vrs_pkg::CTRL_ENABLE_RST;
    end else if (acc && pwrite && paddr == vrs_pkg::CTRL_OFS) begin
      sw_enable_q <= pwdata[vrs_pkg::CTRL_ENABLE_BIT];
    end
  end

  // sticky events, write one to clear, a new event wins
  assign evt_set[vrs_pkg::EVT_LATCH_BIT] = (state_d == vrs_pkg::ST_LATCHED) && (state_q != vrs_pkg::ST_LATCHED);
  assign evt_set[vrs_pkg::EVT_PGFAIL_BIT] = pg_fail;
  assign evt_set[vrs_pkg::EVT_ILIM_BIT] = current_limit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q <= 3'h0;
    end else if (acc && pwrite && paddr == vrs_pkg::EVENT_OFS) begin
      evt_q <= (evt_q & ~pwdata[2:0]) | evt_set;
    end else begin
      evt_q <= evt_q | evt_set;
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        vrs_pkg::CTRL_OFS: prdata_q <= {31'h0000_0000, sw_enable_q};
        vrs_pkg::STATUS_OFS: prdata_q <= {22'h00_0000, full_phase_mode, mask_active, fault_q, power_ok_q,
          !cpu_clock_enable_n_n_q, phase_cnt_q, state_q};
        vrs_pkg::CODE_OFS: prdata_q <= {dac_target_uv100, 1'b0, vid_act_q, 1'b0, dac_code};
        vrs_pkg::EVENT_OFS: prdata_q <= {29'h0000_0000, evt_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata = prdata_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_off_holds_ss:
    assert property ((state_q == vrs_pkg::ST_OFF) |-> ss_discharge && !ss_charge_8ua && !ss_fast_charge)
      else $error("soft-start not held while off");
  a_cpu_clock_enable_n_cause:
    assert property ($fell(cpu_clock_enable_n) |-> $past(ss_at_1v7 && in_window && state_q == vrs_pkg::ST_SOFT))
      else $error("clock enable without 1.7 V and window");
  a_delay_hold:
    assert property (cpu_clock_enable_n |-> pok_delay_discharge && !pok_delay_charge_2ua)
      else $error("delay node not held before clock enable");
  a_pok_cause:
    assert property ($rose(power_ok_q) |-> $past(delay_at_2v9) && !cpu_clock_enable_n && power_ok_oe == 1'b0)
      else $error("power ok without delay termination");
  a_boot_target:
    assert property ((state_q == vrs_pkg::ST_SOFT) |-> dac_code == vrs_pkg::BOOT_CODE && dac_target_uv100 == 16'h2EE0)
      else $error("ramp target is not the boot level");
  a_vid_keepout:
    assert property (vid_change |=> $stable(vid_act_q) [*8])
      else $error("new code used inside the keep-out");
  a_mask_restart:
    assert property (vid_change |=> mask_cnt_q == 16'(MASK_CYCLES_P) ##1 mask_active)
      else $error("mask timer not restarted by code change");
  a_ilim_full:
    assert property (current_limit |-> full_phase_mode)
      else $error("current limit without full-phase mode");
  a_low_target:
    assert property (target_low |-> in_window == vout_below_high_limit)
      else $error("lower limit checked below 300 mV");
  a_latch_off:
    assert property ((state_q == vrs_pkg::ST_RUN && fault_q && ss_below_1v65 && go) |=> state_q == vrs_pkg::ST_LATCHED)
      else $error("no latch-off below 1.65 V");
  a_disable_resets:
    assert property (!go |=> state_q == vrs_pkg::ST_OFF && cpu_clock_enable_n)
      else $error("disable did not restart the sequence");

  c_reach_run: cover property ($fell(cpu_clock_enable_n));
  c_power_ok: cover property ($rose(power_ok_q));
  c_latched: cover property (state_q == vrs_pkg::ST_LATCHED);
  c_vid_move: cover property (vid_change ##[1:60] $changed(vid_act_q));

endmodule : vrs_seq

`default_nettype wire

// ---- test/vrs_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far side: soft-start and delay capacitors
// ----------------------------------------
module vrs_far_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // node controls from the sequencer
  input wire logic ss_discharge,
  input wire logic ss_charge_8ua,
  input wire logic ss_fast_charge,
  input wire logic ss_sink_2ua,
  input wire logic pok_delay_discharge,
  input wire logic pok_delay_charge_2ua,
  // comparator flags back to the sequencer
  output logic ss_at_1v7,
  output logic ss_at_clamp,
  output logic ss_below_1v65,
  output logic delay_at_2v9
);
  // node levels in 10 mV steps; one step a cycle on the slow sources keeps the run short
  int ss_lvl;
  int dly_lvl;

  // soft-start node: slow ramp, fast top-up, slow sink, clamp at 2.9 V
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_lvl <= 0;
    end else if (ss_discharge) begin
      ss_lvl <= 0;
    end else if (ss_fast_charge) begin
      ss_lvl <= (ss_lvl > 280) ? 290 : ss_lvl + 10;
    end else if (ss_charge_8ua && ss_lvl < 290) begin
      ss_lvl <= ss_lvl + 1;
    end else if (ss_sink_2ua && ss_lvl > 0) begin
      ss_lvl <= ss_lvl - 1;
    end
  end

  // delay node: held at zero, else charged up to its 2.9 V level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_lvl <= 0;
    end else if (pok_delay_discharge) begin
      dly_lvl <= 0;
    end else if (pok_delay_charge_2ua && dly_lvl < 290) begin
      dly_lvl <= dly_lvl + 1;
    end
  end

  // flags registered so that they only move at clock edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_at_1v7 <= 1'b0;
      ss_at_clamp <= 1'b0;
      ss_below_1v65 <= 1'b1;
      delay_at_2v9 <= 1'b0;
    end else begin
      ss_at_1v7 <= (ss_lvl >= 170);
      ss_at_clamp <= (ss_lvl >= 290);
      ss_below_1v65 <= (ss_lvl < 165);
      delay_at_2v9 <= (dly_lvl >= 290);
    end
  end
endmodule : vrs_far_model
`default_nettype wire

// ---- test/vrs_seq_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module vrs_seq_tb;
  // ----------------------------------------
  // signals, every driven input given a value at time zero
  // ----------------------------------------
  localparam int unsigned RST_CYC = 20;
  localparam int unsigned MSK_CYC = 50;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er;
  logic chip_enable_input = 1'b0, supply_above_upper = 1'b1, supply_above_lower = 1'b1;
  logic [6:0] voltage_id_code = 7'h20;
  logic deeper_sleep_request = 1'b0, low_power_state_indicator = 1'b0;
  logic phase2_pulled_high = 1'b0, phase3_pulled_high = 1'b1;
  logic ss_at_1v7, ss_at_clamp, ss_below_1v65, delay_at_2v9;
  logic vout_above_low_limit = 1'b1, vout_below_high_limit = 1'b1;
  logic vout_drop_200mv = 1'b0, current_limit = 1'b0;
  logic bias_enable, ss_discharge, ss_charge_8ua, ss_fast_charge, ss_sink_2ua;
  logic pok_delay_discharge, pok_delay_charge_2ua;
  logic [6:0] dac_code;
  logic [15:0] dac_target_uv100;
  logic [1:0] phase_count;
  logic full_phase_mode, cpu_clock_enable_n, power_ok_o, power_ok_oe;
  logic pok_wire;
  int n_fail = 0;
  int n_checks = 0;
  int n;

  // clock, and the open-drain power-good line with its pull-up
  always #5 pclk = ~pclk;
  assign pok_wire = power_ok_oe ? power_ok_o : 1'b1;

  vrs_seq #(.RESET_CYCLES_P(RST_CYC), .MASK_CYCLES_P(MSK_CYC)) vrs_seq_inst (.*);
  vrs_far_model vrs_far_model_inst (.*);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // let k edges pass, then stop mid-cycle where outputs are settled
  task automatic w(input int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask : w

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    w(0);
    chk("ss_held", 1, ss_discharge);
    chk("dly_held", 1, pok_delay_discharge);
    chk("pok_reset", 0, pok_wire);
    chk("bias_off", 0, bias_enable);
    apb(1'b0, vrs_pkg::CTRL_OFS, 32'h0);
    chk("ctrl_rst", 1, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 1, er);
    // start-up: timed reset, phase detect, then ramp
    @(posedge pclk);
    chip_enable_input <= 1'b1;
    w(2);
    chk("bias_on", 1, bias_enable);
    for (n = 2; ss_charge_8ua !== 1'b1 && n < 200; n++) @(negedge pclk);
    chk("reset_len", 1, n >= RST_CYC + 3 && n <= RST_CYC + 6);
    chk("ramp", 1, ss_charge_8ua);
    chk("phases", 2'h2, phase_count);
    chk("boot", 7'h18, dac_code);
    chk("dly_soft", 1, pok_delay_discharge);
    // window missed as the ramp crosses 1.7 V: no clock enable yet
    @(posedge pclk);
    vout_above_low_limit <= 1'b0;
    for (n = 0; ss_at_1v7 !== 1'b1 && n < 400; n++) @(negedge pclk);
    w(5);
    chk("cpu_clock_enable_n_hold", 1, cpu_clock_enable_n);
    @(posedge pclk);
    vout_above_low_limit <= 1'b1;
    w(3);
    chk("cpu_clock_enable_n", 0, cpu_clock_enable_n);
    chk("dly_chg", 1, pok_delay_charge_2ua);
    chk("ss_fast", 1, ss_fast_charge);
    chk("mask_run", 1, full_phase_mode);
    w(60);
    chk("mask_end", 0, full_phase_mode);
    chk("cpu_code", 7'h20, dac_code);
    chk("pok_wait", 0, pok_wire);
    // two code steps: keep-out, then mask restarted by the second
    @(posedge pclk);
    voltage_id_code <= 7'h30;
    w(30);
    chk("keepout", 7'h20, dac_code);
    chk("mask_code", 1, full_phase_mode);
    @(posedge pclk);
    voltage_id_code <= 7'h31;
    w(44);
    chk("mask_rst", 1, full_phase_mode);
    chk("code_new", 7'h31, dac_code);
    chk("target", 16'h22AB, dac_target_uv100);
    w(15);
    chk("mask_off", 0, full_phase_mode);
    for (n = 0; pok_wire !== 1'b1 && n < 400; n++) @(negedge pclk);
    chk("pok", 1, pok_wire);
    chk("pok_late", 1, n > 100);
    // leave the window once, then come back
    @(posedge pclk);
    vout_below_high_limit <= 1'b0;
    w(3);
    chk("pok_drop", 0, pok_wire);
    @(posedge pclk);
    vout_below_high_limit <= 1'b1;
    w(3);
    chk("pok_back", 1, pok_wire);
    apb(1'b0, vrs_pkg::EVENT_OFS, 32'h0);
    chk("evt_pg", 1, rd[vrs_pkg::EVT_PGFAIL_BIT]);
    apb(1'b1, vrs_pkg::EVENT_OFS, 32'h2);
    apb(1'b0, vrs_pkg::EVENT_OFS, 32'h0);
    chk("evt_clr", 0, rd[vrs_pkg::EVT_PGFAIL_BIT]);
    // low target: only the upper limit counts
    @(posedge pclk);
    voltage_id_code <= 7'h61;
    w(110);
    chk("target_low", 16'h0B3B, dac_target_uv100);
    @(posedge pclk);
    vout_above_low_limit <= 1'b0;
    w(5);
    chk("low_ignored", 1, pok_wire);
    // deeper sleep entry masks; a 200 mV droop keeps the mask past its timer
    @(posedge pclk);
    deeper_sleep_request <= 1'b1;
    w(3);
    chk("ds_mask", 1, full_phase_mode);
    @(posedge pclk);
    vout_drop_200mv <= 1'b1;
    w(60);
    chk("ds_drop", 1, full_phase_mode);
    @(posedge pclk);
    vout_drop_200mv <= 1'b0;
    w(2);
    chk("ds_end", 0, full_phase_mode);
    // supply loss discharges both nodes, then a fresh start
    @(posedge pclk);
    supply_above_lower <= 1'b0;
    vout_above_low_limit <= 1'b1;
    w(2);
    chk("ss_dis", 1, ss_discharge);
    chk("dly_dis", 1, pok_delay_discharge);
    chk("cpu_clock_enable_n_off", 1, cpu_clock_enable_n);
    @(posedge pclk);
    supply_above_lower <= 1'b1;
    // code moved while off, so no keep-out is started by it
    voltage_id_code <= 7'h20;
    for (n = 0; cpu_clock_enable_n !== 1'b0 && n < 600; n++) @(negedge pclk);
    chk("restart", 0, cpu_clock_enable_n);
    // let the entry mask run out so only the limit can force full phases
    w(55);
    chk("fpm_idle", 0, full_phase_mode);
    // current limit: full-phase mode, sink, then latch-off
    @(posedge pclk);
    current_limit <= 1'b1;
    w(0);
    chk("ilim_fpm", 1, full_phase_mode);
    w(3);
    chk("ss_sink", 1, ss_sink_2ua);
    for (n = 0; ss_discharge !== 1'b1 && n < 400; n++) @(negedge pclk);
    apb(1'b0, vrs_pkg::STATUS_OFS, 32'h0);
    chk("latched", 3'h5, rd[2:0]);
    end_sim();
  end

  // watchdog at 10000 cycles, well beyond the roughly 1200 cycles the tests need
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end
endmodule : vrs_seq_tb
`default_nettype wire
